// file: core/spi_slave_map.svh
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef SPI_SLAVE_MAP_SVH
`define SPI_SLAVE_MAP_SVH

// Register byte addresses on the APB bus.
`define SPI_ADDR_W 12
`define SPI_OFF_BUF 12'h000
`define SPI_OFF_CON1 12'h004
`define SPI_OFF_CON3 12'h008
`define SPI_OFF_STAT 12'h00c
`define SPI_OFF_IRQ_ST 12'h010
`define SPI_OFF_IRQ_MASK 12'h014

// Field positions in port_control_one.
`define SPI_CON1_WRITE_COLLISION_FLAG 7
`define SPI_CON1_OV 6
`define SPI_CON1_EN 5
`define SPI_CON1_CKP 4

// Field positions in port_control_three and port_status.
`define SPI_CON3_BOEN 4
`define SPI_STAT_SMP 7
`define SPI_STAT_CKE 6
`define SPI_STAT_BF 0

// Bit positions in the interrupt status and mask registers.
`define SPI_IRQ_DONE 0
`define SPI_IRQ_WRITE_COLLISION_FLAG 1
`define SPI_IRQ_OVF 2

// Port mode encodings.
`define SPI_MODE_MASTER 4'h0
`define SPI_MODE_SLAVE_SS 4'h4
`define SPI_MODE_SLAVE_NOSS 4'h5

// Reset values.
`define SPI_RST_BYTE 8'h00
`define SPI_RST_MODE 4'h0
`define SPI_IRQ_RST 3'h0

// Master clock half period in pclk cycles, and toggles in one byte.
`define SPI_MASTER_HALF 4'h2
`define SPI_MASTER_TOGGLES 5'h10
`define SPI_LAST_BIT 3'h7

`endif

// file: core/spi_slave_pkg.sv
// Types shared by the serial port design.
package spi_slave_pkg;

	// Activity of the shift logic, one-hot.
	typedef enum logic [2:0]
	{
		LINK_IDLE = 3'b001,
		LINK_SLAVE = 3'b010,
		LINK_MASTER = 3'b100
	} link_state_t;

	// One data byte.
	typedef logic [7:0] byte_t;

endpackage : spi_slave_pkg

// file: core/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
module pin_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Raw pins and their filtered levels.
	input wire logic [W-1:0] pin_raw,
	output logic [W-1:0] pin_lvl
);

	genvar i;

	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			logic lvl_d;

			// The level follows once the second and third stages agree.
			always_comb
			begin
				lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
			end

			// The first stage feeds only the second stage.
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					s1_q <= RST[i];
					s2_q <= RST[i];
					s3_q <= RST[i];
					lvl_q <= RST[i];
				end
				else
				begin
					s1_q <= pin_raw[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					lvl_q <= lvl_d;
				end
			end

			assign pin_lvl[i] = lvl_q;
		end
	endgenerate

endmodule : pin_sync

// file: core/spi_slave_select_sync.sv
// Synchronous serial port in SPI mode with slave select synchronisation and APB registers.
//
// What this block does
// - While slave select is low in slave-with-select mode, shifting runs and SDO is driven.
// - When slave select rises, SDO stops being driven at once, even in the middle of a byte.
// - Slave-with-select operation is active only when the mode field equals 4'h4.
// - In slave-with-select mode the serial logic is held in reset while slave select is high.
// - A serial reset forces the bit counter to zero; select high or a cleared enable causes it.
// - In master mode Sleep freezes the transfer, which resumes where it stopped on wake.
// - In slave mode the shift register runs from SCK alone, so bytes arrive during Sleep.
// - Data shifts MSB first; after eight bits the byte enters the buffer unless it is still full with BOEN clear, and flags are set.
// - A buffer write during a transfer is dropped and sets a collision flag cleared by software.
// - The clock idle polarity bit sets the SCK idle level, which the master holds beforehand.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`include "spi_slave_map.svh"

module spi_slave_select_sync (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SPI_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial pins.
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic sdi,
	output logic sdo_out,
	output logic sdo_oe,
	input wire logic ss_n_in,
	// Power state and interrupt.
	input wire logic sleep,
	output logic irq,
	output logic wake
);

	// Filtered pin levels: bit 2 select, bit 1 data in, bit 0 clock.
	logic [2:0] pin_lvl;
	logic ss_lvl;
	logic sdi_lvl;
	logic sck_lvl;

	// Configuration and status registers.
	logic en_q, en_d;
	logic ckp_q, ckp_d;
	logic [3:0] mode_q, mode_d;
	logic write_collision_flag_q, write_collision_flag_d;
	logic ov_q, ov_d;
	logic boen_q, boen_d;
	logic smp_q, smp_d;
	logic cke_q, cke_d;
	logic bf_q, bf_d;
	spi_slave_pkg::byte_t buf_q, buf_d;
	logic [2:0] irq_st_q, irq_st_d;
	logic [2:0] irq_mask_q, irq_mask_d;
	logic irq_q, irq_d;
	logic [31:0] prdata_q, prdata_d;

	// Shift engine registers.
	spi_slave_pkg::link_state_t state_q, state_d;
	spi_slave_pkg::byte_t tx_q, tx_d;
	spi_slave_pkg::byte_t rx_q, rx_d;
	logic [2:0] cnt_q, cnt_d;
	logic [3:0] div_q, div_d;
	logic [4:0] tog_q, tog_d;
	logic msck_q, msck_d;
	logic act_prev_q, act_prev_d;
	logic drive_q, drive_d;

	// Combinational helpers.
	logic wr_acc;
	logic rd_acc;
	logic ser_rst;
	logic busy;
	logic act;
	logic lead;
	logic trail;
	logic samp_edge;
	logic shift_edge;
	logic running;
	logic byte_done;
	logic [2:0] irq_evt;
	spi_slave_pkg::byte_t rx_next;

	// True for either slave mode encoding.
	function automatic logic is_slave(input logic [3:0] mode);
		is_slave = (mode == `SPI_MODE_SLAVE_SS) || (mode == `SPI_MODE_SLAVE_NOSS);
	endfunction : is_slave

	// True when an address hits a mapped register.
	function automatic logic is_mapped(input logic [`SPI_ADDR_W-1:0] addr);
		is_mapped = (addr == `SPI_OFF_BUF) || (addr == `SPI_OFF_CON1) ||
			(addr == `SPI_OFF_CON3) || (addr == `SPI_OFF_STAT) ||
			(addr == `SPI_OFF_IRQ_ST) || (addr == `SPI_OFF_IRQ_MASK);
	endfunction : is_mapped

	// Pins from outside the pclk domain; select idles high.
	pin_sync #(
		.W(3),
		.RST(3'h4)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_raw({ss_n_in, sdi, sck_in}),
		.pin_lvl(pin_lvl)
	);

	assign ss_lvl = pin_lvl[2];
	assign sdi_lvl = pin_lvl[1];
	assign sck_lvl = pin_lvl[0];

	// Bus phases: every transfer answers in its first access cycle.
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign prdata = prdata_q;

	// Serial reset from select high or a cleared enable.
	assign ser_rst = !en_q || ((mode_q == `SPI_MODE_SLAVE_SS) && ss_lvl);
	assign busy = (state_q != spi_slave_pkg::LINK_IDLE);
	assign running = en_q && !ser_rst &&
		(is_slave(mode_q) || (state_q == spi_slave_pkg::LINK_MASTER));

	// Active clock phase relative to the idle level; master uses its own clock.
	assign act = ((mode_q == `SPI_MODE_MASTER) ? msck_q : (sck_lvl ^ ckp_q));
	assign lead = act && !act_prev_q;
	assign trail = !act && act_prev_q;
	assign samp_edge = running && (cke_q ? lead : trail);
	assign shift_edge = running && (cke_q ? trail : lead);
	assign rx_next = {rx_q[6:0], sdi_lvl};
	assign byte_done = samp_edge && (cnt_q == `SPI_LAST_BIT);

	// Pin drivers; select high releases SDO without waiting for the synchroniser.
	assign sck_out = msck_q ^ ckp_q;
	assign sck_oe = en_q && (mode_q == `SPI_MODE_MASTER);
	assign sdo_out = tx_q[7];
	assign sdo_oe = drive_q && !((mode_q == `SPI_MODE_SLAVE_SS) && ss_n_in);
	assign irq = irq_q;
	assign wake = irq_q;

	// Next values of registers, shift engine and interrupt logic.
	always_comb
	begin
		en_d = en_q;
		ckp_d = ckp_q;
		mode_d = mode_q;
		write_collision_flag_d = write_collision_flag_q;
		ov_d = ov_q;
		boen_d = boen_q;
		smp_d = smp_q;
		cke_d = cke_q;
		bf_d = bf_q;
		buf_d = buf_q;
		irq_st_d = irq_st_q;
		irq_mask_d = irq_mask_q;
		prdata_d = prdata_q;
		state_d = state_q;
		tx_d = tx_q;
		rx_d = rx_q;
		cnt_d = cnt_q;
		div_d = div_q;
		tog_d = tog_q;
		msck_d = msck_q;
		act_prev_d = act;
		irq_evt = `SPI_IRQ_RST;

		// Read data is captured in the setup cycle.
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				`SPI_OFF_BUF: prdata_d = {24'h000000, buf_q};
				`SPI_OFF_CON1: prdata_d = {24'h000000, write_collision_flag_q, ov_q, en_q, ckp_q, mode_q};
				`SPI_OFF_CON3: prdata_d = {27'h0000000, boen_q, 4'h0};
				`SPI_OFF_STAT: prdata_d = {24'h000000, smp_q, cke_q, 5'h00, bf_q};
				`SPI_OFF_IRQ_ST: prdata_d = {29'h00000000, irq_st_q};
				`SPI_OFF_IRQ_MASK: prdata_d = {29'h00000000, irq_mask_q};
				default: prdata_d = 32'h00000000;
			endcase
		end

		// Read side effects take place at the access edge.
		if (rd_acc && (paddr == `SPI_OFF_BUF))
		begin
			bf_d = 1'b0;
		end
		if (rd_acc && (paddr == `SPI_OFF_IRQ_ST))
		begin
			irq_st_d = `SPI_IRQ_RST;
		end

		// Register writes; the collision and overflow flags are only cleared by writing zero.
		if (wr_acc)
		begin
			case (paddr)
				`SPI_OFF_BUF:
				begin
					if (busy || (cnt_q != 3'h0))
					begin
						irq_evt[`SPI_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
					end
					else
					begin
						buf_d = pwdata[7:0];
						tx_d = pwdata[7:0];
						if (en_q && (mode_q == `SPI_MODE_MASTER))
						begin
							state_d = spi_slave_pkg::LINK_MASTER;
							div_d = 4'h0;
							tog_d = 5'h00;
						end
					end
				end
				`SPI_OFF_CON1:
				begin
					write_collision_flag_d = write_collision_flag_q && pwdata[`SPI_CON1_WRITE_COLLISION_FLAG];
					ov_d = ov_q && pwdata[`SPI_CON1_OV];
					en_d = pwdata[`SPI_CON1_EN];
					ckp_d = pwdata[`SPI_CON1_CKP];
					mode_d = pwdata[3:0];
				end
				`SPI_OFF_CON3: boen_d = pwdata[`SPI_CON3_BOEN];
				`SPI_OFF_STAT:
				begin
					smp_d = pwdata[`SPI_STAT_SMP];
					cke_d = pwdata[`SPI_STAT_CKE];
				end
				`SPI_OFF_IRQ_MASK: irq_mask_d = pwdata[2:0];
				default: irq_mask_d = irq_mask_q;
			endcase
		end

		// Master divider, frozen by Sleep; busy lasts a cycle past the last toggle so it is sampled.
		if ((state_q == spi_slave_pkg::LINK_MASTER) && !sleep)
		begin
			if (tog_q == `SPI_MASTER_TOGGLES)
			begin
				state_d = spi_slave_pkg::LINK_IDLE;
			end
			else if (div_q == (`SPI_MASTER_HALF - 4'h1))
			begin
				div_d = 4'h0;
				msck_d = !msck_q;
				tog_d = tog_q + 5'h01;
			end
			else
			begin
				div_d = div_q + 4'h1;
			end
		end

		// Output shifts after the first sample of a byte, MSB first.
		if (shift_edge && (cnt_q != 3'h0))
		begin
			tx_d = {tx_q[6:0], 1'b0};
		end

		// Input sampling and byte completion, driven by clock edges only.
		if (samp_edge)
		begin
			rx_d = rx_next;
			cnt_d = cnt_q + 3'h1;
			if (is_slave(mode_q))
			begin
				state_d = spi_slave_pkg::LINK_SLAVE;
			end
			if (byte_done)
			begin
				irq_evt[`SPI_IRQ_DONE] = 1'b1;
				if (is_slave(mode_q))
				begin
					state_d = spi_slave_pkg::LINK_IDLE;
				end
				if (bf_q && !boen_q)
				begin
					irq_evt[`SPI_IRQ_OVF] = 1'b1;
				end
				else
				begin
					buf_d = rx_next;
					bf_d = 1'b1;
				end
			end
		end

		// Serial reset realigns the bit counter and drops any partial byte.
		if (ser_rst)
		begin
			cnt_d = 3'h0;
			rx_d = `SPI_RST_BYTE;
			if (!en_q || (state_q == spi_slave_pkg::LINK_SLAVE))
			begin
				state_d = spi_slave_pkg::LINK_IDLE;
			end
			if (!en_q)
			begin
				msck_d = 1'b0;
				div_d = 4'h0;
				tog_d = 5'h00;
			end
		end

		// Hardware events win over clears in the same cycle.
		if (irq_evt[`SPI_IRQ_WRITE_COLLISION_FLAG])
		begin
			write_collision_flag_d = 1'b1;
		end
		if (irq_evt[`SPI_IRQ_OVF])
		begin
			ov_d = 1'b1;
		end
		irq_st_d = irq_st_d | irq_evt;
		irq_d = |(irq_st_d & irq_mask_d);
	end

	// SDO drive enable follows the enabled mode.
	always_comb
	begin
		drive_d = en_d && (is_slave(mode_d) || (mode_d == `SPI_MODE_MASTER));
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_q <= 1'b0;
			ckp_q <= 1'b0;
			mode_q <= `SPI_RST_MODE;
			write_collision_flag_q <= 1'b0;
			ov_q <= 1'b0;
			boen_q <= 1'b0;
			smp_q <= 1'b0;
			cke_q <= 1'b0;
			bf_q <= 1'b0;
			buf_q <= `SPI_RST_BYTE;
			irq_st_q <= `SPI_IRQ_RST;
			irq_mask_q <= `SPI_IRQ_RST;
			irq_q <= 1'b0;
			prdata_q <= 32'h00000000;
			state_q <= spi_slave_pkg::LINK_IDLE;
			tx_q <= `SPI_RST_BYTE;
			rx_q <= `SPI_RST_BYTE;
			cnt_q <= 3'h0;
			div_q <= 4'h0;
			tog_q <= 5'h00;
			msck_q <= 1'b0;
			act_prev_q <= 1'b0;
			drive_q <= 1'b0;
		end
		else
		begin
			en_q <= en_d;
			ckp_q <= ckp_d;
			mode_q <= mode_d;
			write_collision_flag_q <= write_collision_flag_d;
			ov_q <= ov_d;
			boen_q <= boen_d;
			smp_q <= smp_d;
			cke_q <= cke_d;
			bf_q <= bf_d;
			buf_q <= buf_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
			prdata_q <= prdata_d;
			state_q <= state_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			cnt_q <= cnt_d;
			div_q <= div_d;
			tog_q <= tog_d;
			msck_q <= msck_d;
			act_prev_q <= act_prev_d;
			drive_q <= drive_d;
		end
	end

endmodule : spi_slave_select_sync

// file: verif/spi_slave_select_sync_properties.sv
// Checker of pin and bus behaviour at the serial port's boundary.
`include "spi_slave_map.svh"
module spi_slave_select_sync_checker (
	// Clock, reset and APB.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`SPI_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// Pins, power and interrupt.
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic sdo_oe,
	input wire logic ss_n_in,
	input wire logic sleep,
	input wire logic irq,
	input wire logic wake
);
	logic [5:0] con_q;
	logic [5:0] con_d;
	logic mz_q;
	logic mz_d;
	logic wr_acc;
	logic m4;

	// Decode of write accesses and the slave-with-select mode.
	assign wr_acc = psel && penable && pwrite;
	assign m4 = con_q[5] && con_q[3:0] == `SPI_MODE_SLAVE_SS;

	// Shadow of the control fields and of an all-clear mask, as software wrote them.
	always_comb
	begin
		con_d = con_q;
		mz_d = mz_q;
		if (wr_acc && paddr == `SPI_OFF_CON1)
			con_d = pwdata[5:0];
		if (wr_acc && paddr == `SPI_OFF_IRQ_MASK)
			mz_d = pwdata[2:0] == 3'h0;
	end

	// Shadow registers.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			con_q <= 6'h00;
			mz_q <= 1'b1;
		end
		else
		begin
			con_q <= con_d;
			mz_q <= mz_d;
		end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sdo_drive: assert property (m4 && !ss_n_in |-> sdo_oe) else $error("sdo idle");
	a_sdo_release: assert property (m4 && ss_n_in |-> !sdo_oe) else $error("sdo held");
	a_mode_five: assert property (con_q == 6'h25 |-> sdo_oe) else $error("sdo idle");
	a_sck_mode: assert property (sck_oe == (con_q[5] && con_q[3:0] == 4'h0))
		else $error("sck enable wrong");
	a_off_quiet: assert property (!con_q[5] |-> !sdo_oe && !sck_oe) else $error("pins on");
	a_sleep_hold: assert property (sck_oe && sleep && $past(sleep) |-> $stable(sck_out))
		else $error("sck moved in sleep");
	a_irq_wake: assert property (wake == irq) else $error("wake differs");
	a_irq_mask: assert property (mz_q && $past(mz_q) |-> !irq) else $error("masked irq");
	a_bad_addr: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("no slave error");
endmodule : spi_slave_select_sync_checker

bind spi_slave_select_sync spi_slave_select_sync_checker i_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pslverr(pslverr), .sck_out(sck_out), .sck_oe(sck_oe), .sdo_oe(sdo_oe),
	.ss_n_in(ss_n_in), .sleep(sleep), .irq(irq), .wake(wake));

// file: verif/spi_master_model.sv
// Behavioural SPI master driving clock, select and data towards the port.
module spi_master_model (
	// Lines to and from the slave.
	output logic sck,
	output logic ss_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock at its idle level and slave deselected before the port is enabled.
	initial
	begin
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// A released data line keeps changing, so a stale bit is never mistaken for data.
	always #20 mosi = ss_n ? ~mosi : mosi;

	// One frame of nb bits, MSB first, 80 ns clock; the master samples as the clock returns idle, as does the port with CKE clear.
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		#1.5;
		ss_n = 1'b0;
		#100;
		for (int i = 7; i > 7 - nb; i--)
		begin
			mosi = tx[i];
			#20 sck = 1'b1;
			#40 sck = 1'b0;
			rx[i] = miso;
			#20;
		end
		ss_n = 1'b1;
		#100;
	endtask : xfer
endmodule : spi_master_model

// file: verif/spi_slave_select_sync_tb.sv
// Self-checking bench of the serial port over APB with SPI slave and master traffic.
`include "spi_slave_map.svh"
module spi_slave_select_sync_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [`SPI_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic sleep = 1'b0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, sck_out, sck_oe, sdo_out, sdo_oe, irq, wake, err;
	logic m_sck, m_ss_n, m_mosi, miso, sck_prev = 1'b0;
	logic [7:0] rx;
	int bad_count = 0, tests_run = 0, cycles = 0, toggles = 0, t0, t1;

	// The data line floats whenever the port lets go of it.
	assign miso = sdo_oe ? sdo_out : 1'bz;

	spi_master_model i_spi_master_model (.sck(m_sck), .ss_n(m_ss_n), .mosi(m_mosi), .miso(miso));
	spi_slave_select_sync i_spi_slave_select_sync (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sck_in(sck_oe ? sck_out : m_sck), .sck_out(sck_out),
		.sck_oe(sck_oe), .sdi(m_mosi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n_in(m_ss_n),
		.sleep(sleep), .irq(irq), .wake(wake));

	// Clock, cycle limit and a count of master clock changes.
	always #2 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		sck_prev <= sck_out;
		if (sck_out !== sck_prev)
			toggles <= toggles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("tests_run %0d bad_count %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer: setup cycle, then access until pready is sampled high.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, rdv, exp);
	endtask : rd

	// Bounded wait for the interrupt line.
	task automatic wait_irq();
		repeat (400)
			if (irq !== 1'b1)
				@(posedge pclk);
		chk("irq", irq, 1'b1);
	endtask : wait_irq

	// Test sequence.
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd("reset", 12'(4 * i), 32'h0);
		rd("unmapped", 12'h018, 32'h0);
		chk("slverr", err, 1'b1);
		wr(`SPI_OFF_STAT, 32'h81);
		rd("status", `SPI_OFF_STAT, 32'h80);
		wr(`SPI_OFF_STAT, 32'h0);
		$display("test registers done");
		wr(`SPI_OFF_IRQ_MASK, 32'h7);
		wr(`SPI_OFF_CON1, 32'h24);
		wr(`SPI_OFF_BUF, 32'ha5);
		sleep <= 1'b1;
		i_spi_master_model.xfer(8'h3c, 8, rx);
		chk("sdo byte", rx, 8'ha5);
		wait_irq();
		sleep <= 1'b0;
		rd("bf set", `SPI_OFF_STAT, 32'h1);
		rd("irq st", `SPI_OFF_IRQ_ST, 32'h1);
		rd("rx byte", `SPI_OFF_BUF, 32'h3c);
		rd("bf clear", `SPI_OFF_STAT, 32'h0);
		$display("test slave byte done");
		wr(`SPI_OFF_BUF, 32'hc3);
		fork
			i_spi_master_model.xfer(8'h11, 8, rx);
			begin
				repeat (60) @(posedge pclk);
				wr(`SPI_OFF_BUF, 32'h77);
			end
		join
		chk("sdo kept", rx, 8'hc3);
		wait_irq();
		rd("collision", `SPI_OFF_CON1, 32'ha4);
		rd("irq st", `SPI_OFF_IRQ_ST, 32'h3);
		rd("rx byte", `SPI_OFF_BUF, 32'h11);
		wr(`SPI_OFF_CON1, 32'h24);
		rd("write_collision_flag clear", `SPI_OFF_CON1, 32'h24);
		$display("test collision done");
		wr(`SPI_OFF_IRQ_MASK, 32'h0);
		i_spi_master_model.xfer(8'hff, 3, rx);
		wr(`SPI_OFF_BUF, 32'h81);
		i_spi_master_model.xfer(8'h5a, 8, rx);
		chk("realigned", rx, 8'h81);
		repeat (20) @(posedge pclk);
		chk("masked", irq, 1'b0);
		rd("irq st", `SPI_OFF_IRQ_ST, 32'h1);
		rd("rx byte", `SPI_OFF_BUF, 32'h5a);
		wr(`SPI_OFF_IRQ_MASK, 32'h1);
		wr(`SPI_OFF_CON1, 32'h25);
		repeat (2) @(posedge pclk);
		chk("mode five", sdo_oe, 1'b1);
		wr(`SPI_OFF_CON1, 32'h05);
		repeat (2) @(posedge pclk);
		chk("disabled", sdo_oe, 1'b0);
		$display("test resync done");
		wr(`SPI_OFF_CON1, 32'h24);
		wr(`SPI_OFF_STAT, 32'h40);
		wr(`SPI_OFF_BUF, 32'h69);
		i_spi_master_model.xfer(8'h2d, 8, rx);
		chk("cke sdo", rx, 8'h69);
		i_spi_master_model.xfer(8'hb4, 8, rx);
		rd("overflow", `SPI_OFF_CON1, 32'h64);
		rd("irq st", `SPI_OFF_IRQ_ST, 32'h5);
		rd("kept byte", `SPI_OFF_BUF, 32'h2d);
		wr(`SPI_OFF_STAT, 32'h0);
		$display("test edge select done");
		wr(`SPI_OFF_CON1, 32'h20);
		t0 = toggles;
		wr(`SPI_OFF_BUF, 32'h96);
		repeat (5) @(posedge pclk);
		sleep <= 1'b1;
		repeat (3) @(posedge pclk);
		t1 = toggles;
		repeat (30) @(posedge pclk);
		chk("frozen", toggles - t1, 32'h0);
		sleep <= 1'b0;
		wait_irq();
		chk("toggles", toggles - t0, 32'h10);
		$display("test master sleep done");
		summarize();
	end
endmodule : spi_slave_select_sync_tb
